// >>> cste_pkg.sv
package cste_pkg;

  // data path width: longest transfer length
  localparam int DW = 16;
  // receive buffer entries
  localparam logic [1:0] BUF_DEPTH = 2'h2;

  // serial_control_0 field positions
  localparam int C0_PWR = 7; // unit_power_enable
  localparam int C0_TXE = 6; // transmit_enable
  localparam int C0_RXE = 5; // receive_enable
  localparam int C0_DIR = 4; // bit_order_select, 0 = msb first
  localparam int C0_TMS = 1; // continuous transfer select
  localparam int C0_SCE = 0; // continue_receive_enable

  // serial_control_1 field positions
  localparam int C1_CKP = 4; // clock_polarity
  localparam int C1_DAP = 3; // data_phase
  localparam int C1_CKS_MSB = 2; // clock_source_select top bit
  localparam int C1_CKS_LSB = 0; // clock_source_select bottom bit
  localparam logic [2:0] CKS_MASTER = 3'h0; // peripheral clock / 2, master
  localparam logic [2:0] CKS_EXT = 3'h7; // external serial clock, slave

  // length_control field
  localparam int C2_CL_MSB = 3;
  localparam logic [3:0] CL_8BIT = 4'h0; // 0000 selects 8 bits
  localparam logic [3:0] CL_TOP = 4'h8; // codes above this clamp to 16 bits
  localparam logic [4:0] LEN_BASE = 5'h08;
  localparam logic [4:0] LEN_MAX = 5'h10;

  // values after reset
  localparam logic [7:0] CTL0_RST = 8'h00;
  localparam logic [7:0] CTL1_RST = 8'h00;
  localparam logic [7:0] CTL2_RST = 8'h00;

  // timing: system clock period and the /2 communication clock
  localparam int FXX_PERIOD_NS = 40;
  localparam int FCCLK_DIV = 2;
  // serial clock half period in system cycles: one communication clock
  localparam int SCK_HALF_CYC = FCCLK_DIV;
  localparam logic [1:0] SCK_HALF_LAST = 2'(SCK_HALF_CYC - 1);

  typedef logic [DW-1:0] cste_word_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } cste_fsm_t;

  // whole state of the engine
  typedef struct packed {
    cste_fsm_t fsm;
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic tsf;
    cste_word_t txb;
    logic txb_full;
    cste_word_t tx_sh;
    cste_word_t rx_sh;
    logic [4:0] bit_cnt;
    logic lvl;
    logic prev;
    logic sck_o;
    logic sck_oe;
    logic so;
    logic rx_irq;
    logic tx_irq;
    logic ove;
    cste_word_t rx_data;
    logic rx_valid;
  } cste_top_st_t;

  // serial clock divider state
  typedef struct packed {
    logic [1:0] cnt;
    logic tick;
  } cste_div_st_t;

  // receive buffer state
  typedef struct packed {
    cste_word_t [1:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } cste_buf_st_t;

endpackage : cste_pkg

// >>> cste_sck_div.sv
`timescale 1ns/1ps
module cste_sck_div (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  output logic tick_o
);
  cste_pkg::cste_div_st_t st_q; // registered state
  cste_pkg::cste_div_st_t st_d; // next state

  assign tick_o = st_q.tick;

  // one tick per half serial clock while running
  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (!run_i) begin
      // restart so the first half period is always whole
      st_d.cnt = 2'h0;
    end else if (st_q.cnt == cste_pkg::SCK_HALF_LAST) begin
      st_d.cnt = 2'h0;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 2'h1;
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule : cste_sck_div

// >>> cste_rxbuf.sv
`timescale 1ns/1ps
module cste_rxbuf (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire cste_pkg::cste_word_t in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output cste_pkg::cste_word_t out_data_o
);
  cste_pkg::cste_buf_st_t st_q; // registered state
  cste_pkg::cste_buf_st_t st_d; // next state
  logic push; // word accepted
  logic pop; // word drained

  assign in_ready_o = st_q.cnt != cste_pkg::BUF_DEPTH;
  assign out_valid_o = st_q.cnt != 2'h0;
  assign out_data_o = st_q.mem[st_q.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // two entries ride out one unread word plus the one in flight
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wp] = in_data_i;
      st_d.wp = !st_q.wp;
    end
    if (pop) begin
      st_d.rp = !st_q.rp;
    end
    // count moves only when one side acts alone
    if (push && !pop) begin
      st_d.cnt = st_q.cnt + 2'h1;
    end else if (pop && !push) begin
      st_d.cnt = st_q.cnt - 2'h1;
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule : cste_rxbuf

// >>> cste_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// R01: control_1 07H slave external clock, 00H master
// R02: clock source 000 internal/2, 111 external pin
// R03: bit order 0 msb first, type 1 clocking
// R04: length code 0000 gives 8-bit transfers
// R05: control_0 A1H single receive-only msb first
// R06: control_0 E1H single transmit-receive msb first
// R07: control_0 C3H continuous transmit-only msb first
// R08: control_0 A3H continuous receive-only msb first
// R09: receive-only dummy read sets active flag, starts
// R10: master transmit write sets flag, drives clock
// R11: slave shifts out and captures per clock
// R12: single word end: stop, receive irq, clear
// R13: read with continue bit restarts, else data
// R14: transmit buffer moved to shifter raises ready irq
// R15: early transmit write chains next word directly
// R16: no new transmit data ends, clears flag
// R17: continuous transmit-only never raises receive irq
// R18: continuous receive word raises irq, may restart
// R19: continue bit cleared stops after current word
// R20: overrun ends continuous reception sequence
// R21: software writes transmit before master clocks
// R22: software disables only after flag is zero
module cste_top (
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  input wire logic CONTROL0_WR_I,
  input wire logic [7:0] CONTROL0_DATA_I,
  input wire logic CONTROL1_WR_I,
  input wire logic [7:0] CONTROL1_DATA_I,
  input wire logic LENGTH_WR_I,
  input wire logic [7:0] LENGTH_DATA_I,
  input wire logic TRANSMIT_WR_I,
  input wire cste_pkg::cste_word_t TRANSMIT_DATA_I,
  input wire logic RECEIVE_RD_I,
  output cste_pkg::cste_word_t RECEIVE_DATA_O,
  output logic RECEIVE_VALID_O,
  output logic TRANSFER_ACTIVE_O,
  output logic TRANSMIT_FULL_O,
  output logic OVERRUN_O,
  output logic RECEIVE_DONE_IRQ_O,
  output logic TRANSMIT_READY_IRQ_O,
  input wire logic SERIAL_CLOCK_I,
  output logic SERIAL_CLOCK_O,
  output logic SERIAL_CLOCK_OE_O,
  output logic SERIAL_OUT_O,
  input wire logic SERIAL_IN_I
);
  localparam cste_pkg::cste_top_st_t ST_RST = '{
    fsm: cste_pkg::ST_IDLE,
    ctl0: cste_pkg::CTL0_RST,
    ctl1: cste_pkg::CTL1_RST,
    ctl2: cste_pkg::CTL2_RST,
    lvl: 1'b1,
    prev: 1'b1,
    sck_o: 1'b1,
    default: '0
  };

  cste_pkg::cste_top_st_t st_q; // registered state
  cste_pkg::cste_top_st_t st_d; // next state
  logic pwr, txe, rxe, dir, tms, sce, ckp, master; // decoded controls
  logic [3:0] len_code; // raw length field
  logic [4:0] len; // bits per word
  logic [3:0] msb_idx; // position of first bit when msb first
  logic div_tick; // half period of master clock elapsed
  logic run_master; // divider enable
  logic buf_in_ready; // receive buffer has room
  logic buf_out_valid; // receive buffer holds a word
  cste_pkg::cste_word_t buf_out_data; // oldest received word
  cste_pkg::cste_word_t rx_word; // finished word, right aligned
  cste_pkg::cste_word_t rx_next; // shifter after capture
  cste_pkg::cste_word_t tx_next; // shifter after shift
  cste_pkg::cste_word_t tx_src; // next word to load in continuous mode
  logic word_done, fall, rise, cur_lvl, ovr_now, more_tx, tx_wr_now;

  // field decode from stored control bytes
  assign pwr = st_q.ctl0[cste_pkg::C0_PWR];
  assign txe = st_q.ctl0[cste_pkg::C0_TXE];
  assign rxe = st_q.ctl0[cste_pkg::C0_RXE];
  assign dir = st_q.ctl0[cste_pkg::C0_DIR];
  assign tms = st_q.ctl0[cste_pkg::C0_TMS];
  assign sce = st_q.ctl0[cste_pkg::C0_SCE];
  assign ckp = st_q.ctl1[cste_pkg::C1_CKP];
  // every internal source runs at fxx/2 here; only 111 means slave
  assign master = st_q.ctl1[cste_pkg::C1_CKS_MSB:cste_pkg::C1_CKS_LSB] != cste_pkg::CKS_EXT; // R02
  assign len_code = st_q.ctl2[cste_pkg::C2_CL_MSB:0];
  // 0000 is 8 bits, larger codes add bits up to 16
  assign len = (len_code > cste_pkg::CL_TOP) ? cste_pkg::LEN_MAX : 5'(cste_pkg::LEN_BASE + {1'b0, len_code}); // R04
  assign msb_idx = 4'(len - 5'h01);
  assign run_master = (st_q.fsm == cste_pkg::ST_RUN) && master;

  // outputs straight from the state register
  assign RECEIVE_DATA_O = st_q.rx_data;
  assign RECEIVE_VALID_O = st_q.rx_valid;
  assign TRANSFER_ACTIVE_O = st_q.tsf;
  assign TRANSMIT_FULL_O = st_q.txb_full;
  assign OVERRUN_O = st_q.ove;
  assign RECEIVE_DONE_IRQ_O = st_q.rx_irq;
  assign TRANSMIT_READY_IRQ_O = st_q.tx_irq;
  assign SERIAL_CLOCK_O = st_q.sck_o;
  assign SERIAL_CLOCK_OE_O = st_q.sck_oe;
  assign SERIAL_OUT_O = st_q.so;

  // first bit on the line for a word in either order
  function automatic logic pick_bit(cste_pkg::cste_word_t w, logic lsb_first, logic [3:0] top);
    pick_bit = lsb_first ? w[0] : w[top];
  endfunction : pick_bit

  // master serial clock timebase
  cste_sck_div u_div (
    .clk_i(CLK_SYS_I),
    .rst_n_i(NRST_I),
    .run_i(run_master),
    .tick_o(div_tick)
  );

  // finished words wait here so a read up to one word late loses nothing
  cste_rxbuf u_rxbuf (
    .clk_i(CLK_SYS_I),
    .rst_n_i(NRST_I),
    .in_valid_i(word_done && rxe),
    .in_ready_o(buf_in_ready),
    .in_data_i(rx_word),
    .out_valid_o(buf_out_valid),
    .out_ready_i(RECEIVE_RD_I),
    .out_data_o(buf_out_data)
  );

  // whole engine: control writes, edges, word end, starts
  always_comb begin
    st_d = st_q;
    st_d.rx_irq = 1'b0;
    st_d.tx_irq = 1'b0;
    word_done = 1'b0;
    ovr_now = 1'b0;
    fall = 1'b0;
    rise = 1'b0;
    cur_lvl = SERIAL_CLOCK_I ^ ckp;
    tx_next = dir ? (st_q.tx_sh >> 1) : (st_q.tx_sh << 1);
    rx_next = dir ? {SERIAL_IN_I, st_q.rx_sh[cste_pkg::DW-1:1]} : {st_q.rx_sh[cste_pkg::DW-2:0], SERIAL_IN_I};
    // lsb first fills from the top, so slide down to the word length
    rx_word = dir ? (rx_next >> (cste_pkg::LEN_MAX - len)) : rx_next;
    tx_wr_now = TRANSMIT_WR_I && pwr && txe;
    more_tx = st_q.txb_full || tx_wr_now;
    tx_src = st_q.txb_full ? st_q.txb : TRANSMIT_DATA_I;
    st_d.prev = cur_lvl;

    // control bytes
    if (CONTROL0_WR_I) begin
      st_d.ctl0 = CONTROL0_DATA_I; // R05 R06 R07 R08
    end
    if (CONTROL1_WR_I) begin
      st_d.ctl1 = CONTROL1_DATA_I; // R01
    end
    if (LENGTH_WR_I) begin
      st_d.ctl2 = LENGTH_DATA_I; // R04
    end

    // receive side of the processor: read pops and clears overrun
    if (RECEIVE_RD_I && buf_out_valid) begin
      st_d.rx_data = buf_out_data;
    end
    st_d.rx_valid = buf_out_valid;
    if (RECEIVE_RD_I) begin
      st_d.ove = 1'b0;
    end

    // serial clock edges in type 1 sense: fall shifts, rise samples
    if (st_q.fsm == cste_pkg::ST_RUN) begin
      if (master) begin
        fall = div_tick && st_q.lvl; // R10
        rise = div_tick && !st_q.lvl; // R10
      end else begin
        fall = st_q.prev && !cur_lvl; // R11
        rise = !st_q.prev && cur_lvl; // R11
      end
    end
    if (fall) begin
      st_d.lvl = 1'b0;
      // first bit is already on the line from load
      if (st_q.bit_cnt != 5'h00) begin
        st_d.tx_sh = tx_next; // R11
        st_d.so = txe && pick_bit(tx_next, dir, msb_idx); // R03
      end else begin
        // a chained word shows its first bit only now, so the last bit holds past its rise
        st_d.so = txe && pick_bit(st_q.tx_sh, dir, msb_idx); // R15
      end
    end
    if (rise) begin
      st_d.lvl = 1'b1;
      st_d.rx_sh = rx_next; // R11
      st_d.bit_cnt = st_q.bit_cnt + 5'h01;
      word_done = (st_q.bit_cnt + 5'h01) == len; // R04
    end

    // end of word, at its last rising edge
    if (word_done) begin
      ovr_now = rxe && !buf_in_ready;
      st_d.ove = st_d.ove || ovr_now; // set beats a same-cycle read
      if (!(tms && txe && !rxe)) begin
        st_d.rx_irq = 1'b1; // R12 R17 R18
      end
      st_d.bit_cnt = 5'h00;
      st_d.rx_sh = '0;
      if (tms && txe && more_tx && !ovr_now) begin
        // chain: buffered word first, a same-cycle write refills it
        st_d.tx_sh = tx_src; // R15
        st_d.tx_irq = 1'b1; // R14
        st_d.txb_full = st_q.txb_full && tx_wr_now;
        st_d.txb = TRANSMIT_DATA_I;
      end else if (tms && !txe && sce && !ovr_now) begin
        st_d.fsm = cste_pkg::ST_RUN; // R18
      end else begin
        st_d.fsm = cste_pkg::ST_IDLE; // R12 R16 R19 R20
        st_d.tsf = 1'b0; // R12 R16 R19 R20
      end
    end

    // starts and buffered writes
    unique case (st_q.fsm)
      cste_pkg::ST_IDLE: begin
        if (tx_wr_now) begin
          st_d.fsm = cste_pkg::ST_RUN; // R10 R11
          st_d.tsf = 1'b1; // R10
          st_d.tx_sh = TRANSMIT_DATA_I;
          st_d.so = pick_bit(TRANSMIT_DATA_I, dir, msb_idx); // R03
          st_d.bit_cnt = 5'h00;
          st_d.rx_sh = '0;
          st_d.lvl = 1'b1;
          // continuous mode frees the buffer at once
          st_d.tx_irq = tms; // R14
        end else if (RECEIVE_RD_I && pwr && rxe && !txe && sce) begin
          st_d.fsm = cste_pkg::ST_RUN; // R09 R13
          st_d.tsf = 1'b1; // R09
          st_d.bit_cnt = 5'h00;
          st_d.rx_sh = '0;
          st_d.lvl = 1'b1;
          st_d.so = 1'b0;
        end
      end
      cste_pkg::ST_RUN: begin
        // single mode ignores writes while busy
        if (tx_wr_now && tms && !word_done) begin
          st_d.txb = TRANSMIT_DATA_I; // R15
          st_d.txb_full = 1'b1;
        end
      end
      default: begin
        st_d.fsm = cste_pkg::ST_IDLE;
        st_d.tsf = 1'b0;
      end
    endcase

    // power off aborts whatever runs
    if (!pwr) begin
      st_d.fsm = cste_pkg::ST_IDLE;
      st_d.tsf = 1'b0;
      st_d.txb_full = 1'b0;
      st_d.bit_cnt = 5'h00;
      st_d.lvl = 1'b1;
    end

    // pin drive follows the next control state
    st_d.sck_oe = st_d.ctl0[cste_pkg::C0_PWR] &&
      (st_d.ctl1[cste_pkg::C1_CKS_MSB:cste_pkg::C1_CKS_LSB] != cste_pkg::CKS_EXT); // R01 R02
    st_d.sck_o = st_d.lvl ^ st_d.ctl1[cste_pkg::C1_CKP]; // R03
  end

  // state register
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!NRST_I);

  slave_mode_a: assert property ( // R01
    (CONTROL1_WR_I && CONTROL1_DATA_I == 8'h07) ##1 !CONTROL1_WR_I |=> !SERIAL_CLOCK_OE_O)
    else $error("slave setting still drives the serial clock");

  master_drive_a: assert property ( // R02
    (CONTROL1_WR_I && CONTROL1_DATA_I == 8'h00 && !CONTROL0_WR_I && pwr) ##1 (!CONTROL1_WR_I && !CONTROL0_WR_I)
      |=> SERIAL_CLOCK_OE_O)
    else $error("master setting does not drive the serial clock");

  first_bit_a: assert property ( // R03
    (st_q.fsm == cste_pkg::ST_IDLE && tx_wr_now && !dir && len == 5'h08)
      |=> SERIAL_OUT_O == $past(TRANSMIT_DATA_I[7]))
    else $error("first bit out is not the msb");

  bit_count_a: assert property ( // R04
    st_q.fsm == cste_pkg::ST_RUN |-> st_q.bit_cnt < len)
    else $error("bit counter passed the word length");

  tx_start_a: assert property ( // R10
    (st_q.fsm == cste_pkg::ST_IDLE && tx_wr_now) |=> TRANSFER_ACTIVE_O && st_q.fsm == cste_pkg::ST_RUN)
    else $error("transmit write did not start a transfer");

  rx_start_a: assert property ( // R09
    (st_q.fsm == cste_pkg::ST_IDLE && RECEIVE_RD_I && pwr && rxe && !txe && sce) |=> TRANSFER_ACTIVE_O)
    else $error("dummy read did not set the active flag");

  single_end_a: assert property ( // R12
    (word_done && !tms && pwr) |=> RECEIVE_DONE_IRQ_O && !TRANSFER_ACTIVE_O)
    else $error("single word end did not stop with receive irq");

  no_rx_irq_a: assert property ( // R17
    RECEIVE_DONE_IRQ_O |-> !$past(tms && txe && !rxe))
    else $error("receive irq in continuous transmit-only mode");

  chain_next_a: assert property ( // R15
    (word_done && pwr && tms && txe && st_q.txb_full && !(rxe && !buf_in_ready))
      |=> TRANSFER_ACTIVE_O && TRANSMIT_READY_IRQ_O)
    else $error("buffered transmit word did not chain");

  tx_stop_a: assert property ( // R16
    (word_done && tms && txe && !st_q.txb_full && !TRANSMIT_WR_I) |=> !TRANSFER_ACTIVE_O)
    else $error("continuous transmit did not end without new data");

  rx_cont_a: assert property ( // R18
    (word_done && pwr && tms && !txe && sce && buf_in_ready) |=> TRANSFER_ACTIVE_O ##0 RECEIVE_DONE_IRQ_O)
    else $error("continuous reception did not restart");

  rx_halt_a: assert property ( // R19
    (word_done && tms && !txe && !sce) |=> !TRANSFER_ACTIVE_O ##1 !SERIAL_CLOCK_O == ckp)
    else $error("continuous reception did not halt");

  overrun_a: assert property ( // R20
    (word_done && tms && rxe && !buf_in_ready) |=> OVERRUN_O && !TRANSFER_ACTIVE_O)
    else $error("overrun did not end the sequence");

endmodule : cste_top

// >>> cste_peer.sv
`timescale 1ns/1ps
// far-side serial party: follows the device clock, or makes its own
module cste_peer (
  input wire logic clk_i,
  input wire logic sck_i, // clock wire level
  input wire logic so_i, // device data out
  input wire logic lead_i, // peer makes the clock
  input wire logic arm_i, // one-cycle frame start
  input wire logic [15:0] word_i, // sent top bit first
  input wire logic [4:0] len_i, // rising edges per frame
  input wire logic [3:0] half_i, // half period when leading
  output logic sck_o,
  output logic sck_oe_o,
  output logic si_o,
  output logic [15:0] got_o,
  output logic [4:0] rise_o
);
  logic busy_q = 1'b0, prev_q = 1'b1, first_q = 1'b0, tog_q = 1'b0; // frame, edge and filler state
  logic [15:0] sh_q = 16'h0000; // outgoing bits
  logic [3:0] tmr_q = 4'h0; // half period timer
  // known values before the first frame
  initial begin
    sck_o = 1'b1;
    got_o = 16'h0000;
    rise_o = 5'h00;
  end
  // clock driven only within a frame; a released data line toggles so a stale bit never passes
  assign sck_oe_o = lead_i & busy_q;
  assign si_o = busy_q ? sh_q[15] : tog_q;
  // shift on falls after the first, capture on rises; edges are counted even after the frame
  always @(posedge clk_i) begin
    prev_q <= sck_i;
    tog_q <= ~tog_q;
    if (arm_i) begin
      busy_q <= 1'b1;
      first_q <= 1'b1;
      sh_q <= word_i;
      rise_o <= 5'h00;
      tmr_q <= 4'h0;
      sck_o <= 1'b1;
    end else begin
      if (prev_q && !sck_i) begin
        first_q <= 1'b0;
        if (!first_q) sh_q <= {sh_q[14:0], 1'b0};
      end
      if (!prev_q && sck_i) begin
        got_o <= {got_o[14:0], so_i};
        rise_o <= rise_o + 5'h01;
        if (rise_o + 5'h01 == len_i) busy_q <= 1'b0;
      end
      // leading: toggle each half period, first toggle is a fall
      if (lead_i && busy_q) begin
        tmr_q <= (tmr_q == half_i) ? 4'h0 : tmr_q + 4'h1;
        if (tmr_q == half_i) sck_o <= ~sck_o;
      end
    end
  end
endmodule : cste_peer

// >>> clocked_serial_transfer_engine_tb.sv
`timescale 1ns/1ps
// self-checking bench for the serial transfer engine
module clocked_serial_transfer_engine_tb;
  typedef struct packed {
    logic [7:0] c1;
    logic [7:0] c0;
    logic [15:0] tx;
    logic [7:0] si;
    logic [3:0] half;
  } cste_row_t;
  logic CLK_SYS_I = 1'b0, NRST_I = 1'b0;
  logic CONTROL0_WR_I = 1'b0, CONTROL1_WR_I = 1'b0, LENGTH_WR_I = 1'b0, TRANSMIT_WR_I = 1'b0, RECEIVE_RD_I = 1'b0;
  logic [7:0] CONTROL0_DATA_I = 8'h00, CONTROL1_DATA_I = 8'h00, LENGTH_DATA_I = 8'h00;
  cste_pkg::cste_word_t TRANSMIT_DATA_I = 16'h0000, RECEIVE_DATA_O;
  logic RECEIVE_VALID_O, TRANSFER_ACTIVE_O, TRANSMIT_FULL_O, OVERRUN_O, RECEIVE_DONE_IRQ_O, TRANSMIT_READY_IRQ_O;
  logic SERIAL_CLOCK_O, SERIAL_CLOCK_OE_O, SERIAL_OUT_O;
  wire logic SERIAL_CLOCK_I, SERIAL_IN_I;
  int mismatches = 0, num_checks = 0, rx_irqs = 0, tx_irqs = 0, cycles = 0, base = 0;
  logic p_arm = 1'b0, p_lead = 1'b0, p_sck, p_sck_oe; // far-side controls
  logic [15:0] p_word = 16'h0000, p_got; // far-side data
  logic [4:0] p_len = 5'h08, p_rise; // far-side edge counts
  logic [3:0] p_half = 4'h3; // far-side speed
  cste_row_t r;
  // control_1, control_0, transmit word, far-side byte, far-side half period
  cste_row_t rows [4] = '{
    '{8'h00, 8'he1, 16'h00a5, 8'h3c, 4'h3},
    '{8'h00, 8'ha1, 16'h0000, 8'hc3, 4'h3},
    '{8'h07, 8'ha1, 16'h0000, 8'h96, 4'h3},
    '{8'h07, 8'he1, 16'h005a, 8'h81, 4'h7}
  };
  // serial clock wire: a pull-up holds it high when nobody drives
  assign SERIAL_CLOCK_I = SERIAL_CLOCK_OE_O ? SERIAL_CLOCK_O : (p_sck_oe ? p_sck : 1'b1);
  cste_top dut (
    .CLK_SYS_I(CLK_SYS_I), .NRST_I(NRST_I), .CONTROL0_WR_I(CONTROL0_WR_I), .CONTROL0_DATA_I(CONTROL0_DATA_I),
    .CONTROL1_WR_I(CONTROL1_WR_I), .CONTROL1_DATA_I(CONTROL1_DATA_I), .LENGTH_WR_I(LENGTH_WR_I),
    .LENGTH_DATA_I(LENGTH_DATA_I), .TRANSMIT_WR_I(TRANSMIT_WR_I), .TRANSMIT_DATA_I(TRANSMIT_DATA_I),
    .RECEIVE_RD_I(RECEIVE_RD_I), .RECEIVE_DATA_O(RECEIVE_DATA_O), .RECEIVE_VALID_O(RECEIVE_VALID_O),
    .TRANSFER_ACTIVE_O(TRANSFER_ACTIVE_O), .TRANSMIT_FULL_O(TRANSMIT_FULL_O), .OVERRUN_O(OVERRUN_O),
    .RECEIVE_DONE_IRQ_O(RECEIVE_DONE_IRQ_O), .TRANSMIT_READY_IRQ_O(TRANSMIT_READY_IRQ_O),
    .SERIAL_CLOCK_I(SERIAL_CLOCK_I), .SERIAL_CLOCK_O(SERIAL_CLOCK_O), .SERIAL_CLOCK_OE_O(SERIAL_CLOCK_OE_O),
    .SERIAL_OUT_O(SERIAL_OUT_O), .SERIAL_IN_I(SERIAL_IN_I)
  );
  cste_peer peer (
    .clk_i(CLK_SYS_I), .sck_i(SERIAL_CLOCK_I), .so_i(SERIAL_OUT_O), .lead_i(p_lead), .arm_i(p_arm),
    .word_i(p_word), .len_i(p_len), .half_i(p_half), .sck_o(p_sck), .sck_oe_o(p_sck_oe), .si_o(SERIAL_IN_I),
    .got_o(p_got), .rise_o(p_rise)
  );
  // 25 MHz system clock
  initial begin
    forever #20 CLK_SYS_I = ~CLK_SYS_I;
  end
  // irq pulses last one cycle, so count them at every edge; cycle ceiling cuts a hang
  always @(posedge CLK_SYS_I) begin
    rx_irqs <= rx_irqs + int'(RECEIVE_DONE_IRQ_O === 1'b1);
    tx_irqs <= tx_irqs + int'(TRANSMIT_READY_IRQ_O === 1'b1);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      results();
    end
  end
  // word and flag comparison
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : check
  // event count comparison
  task automatic check_n(input string name, input int exp, input int got);
    num_checks++;
    if (got != exp) begin
      mismatches++;
      $display("unexpected %s: expected %0d seen %0d", name, exp, got);
    end
  endtask : check_n
  // verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  // all three control bytes on one edge; length code 0000 means 8 bits
  task automatic setup(input logic [7:0] c1, input logic [7:0] c0);
    @(posedge CLK_SYS_I);
    CONTROL1_WR_I <= 1'b1;
    CONTROL1_DATA_I <= c1;
    LENGTH_WR_I <= 1'b1;
    LENGTH_DATA_I <= 8'h00;
    CONTROL0_WR_I <= 1'b1;
    CONTROL0_DATA_I <= c0;
    @(posedge CLK_SYS_I);
    {CONTROL1_WR_I, LENGTH_WR_I, CONTROL0_WR_I} <= 3'h0;
    #1;
  endtask : setup
  // one strobe: 0 transmit write, 1 receive read, 2 control_0 write
  task automatic pulse(input int k, input logic [15:0] d);
    @(posedge CLK_SYS_I);
    if (k == 0) begin
      TRANSMIT_WR_I <= 1'b1;
      TRANSMIT_DATA_I <= d;
    end else if (k == 1) begin
      RECEIVE_RD_I <= 1'b1;
    end else begin
      CONTROL0_WR_I <= 1'b1;
      CONTROL0_DATA_I <= d[7:0];
    end
    @(posedge CLK_SYS_I);
    {TRANSMIT_WR_I, RECEIVE_RD_I, CONTROL0_WR_I} <= 3'h0;
    #1;
  endtask : pulse
  // start a far-side frame
  task automatic arm(input logic lead, input logic [15:0] w, input logic [4:0] n);
    @(posedge CLK_SYS_I);
    p_arm <= 1'b1;
    p_lead <= lead;
    p_word <= w;
    p_len <= n;
    @(posedge CLK_SYS_I);
    p_arm <= 1'b0;
    #1;
  endtask : arm
  // bounded wait: 0 receive irqs, 1 transmit irqs, 2 active flag low
  task automatic wait_for(input int s, input int target, input int lim);
    int v;
    v = 0;
    num_checks++;
    for (int n = 0; n < lim; n++) begin
      @(posedge CLK_SYS_I);
      #1;
      v = (s == 0) ? rx_irqs : (s == 1) ? tx_irqs : int'(TRANSFER_ACTIVE_O === 1'b0);
      if (v >= target) return;
    end
    mismatches++;
    $display("unexpected wait %0d: expected %0d seen %0d", s, target, v);
  endtask : wait_for
  // pop one word and compare it
  task automatic read_word(input logic [15:0] exp);
    check("rx_valid", 16'h0001, {15'h0000, RECEIVE_VALID_O});
    pulse(1, 16'h0000);
    @(posedge CLK_SYS_I);
    #1;
    check("rx_word", exp, RECEIVE_DATA_O);
  endtask : read_word
  initial begin
    repeat (20) @(posedge CLK_SYS_I);
    NRST_I <= 1'b1;
    @(posedge CLK_SYS_I);
    #1;
    check("reset_out", 16'h0001, {11'h000, TRANSFER_ACTIVE_O, RECEIVE_VALID_O, OVERRUN_O, SERIAL_CLOCK_OE_O, SERIAL_CLOCK_O});
    // single transfers, master and slave, two rows each
    for (int i = 0; i < 4; i++) begin
      r = rows[i];
      p_half = r.half;
      setup(r.c1, r.c0);
      check("clock_drive", {15'h0000, r.c1 != 8'h07}, {15'h0000, SERIAL_CLOCK_OE_O});
      base = rx_irqs;
      if (r.c1 != 8'h07) arm(1'b0, {r.si, 8'h00}, 5'h08);
      pulse(r.c0[6] ? 0 : 1, r.tx);
      if (r.c1 == 8'h07) arm(1'b1, {r.si, 8'h00}, 5'h08);
      else @(posedge CLK_SYS_I);
      #1;
      check("active_set", 16'h0001, {15'h0000, TRANSFER_ACTIVE_O});
      wait_for(0, base + 1, 300);
      wait_for(2, 1, 4);
      if (r.c0[6]) check("peer_word", r.tx, {8'h00, p_got[7:0]});
      pulse(2, {8'h00, r.c0 & 8'hfe});
      read_word({8'h00, r.si});
      check("read_only", 16'h0000, {15'h0000, TRANSFER_ACTIVE_O});
      check("edge_count", 16'h0008, {11'h000, p_rise});
    end
    // continuous transmit: second word written while the first shifts
    setup(8'h00, 8'hc3);
    base = rx_irqs;
    arm(1'b0, 16'h0000, 5'h10);
    pulse(0, 16'h00a5);
    wait_for(1, 1, 4);
    pulse(0, 16'h005c);
    @(posedge CLK_SYS_I);
    #1;
    check("tx_held", 16'h0001, {15'h0000, TRANSMIT_FULL_O});
    wait_for(1, 2, 60);
    wait_for(2, 1, 60);
    // the far side sees the last rise one edge later
    @(posedge CLK_SYS_I) #1;
    check("chain_word", 16'ha55c, p_got);
    check("chain_edges", 16'h0010, {11'h000, p_rise});
    check_n("rx_irq_none", base, rx_irqs);
    // continuous receive, stopped by clearing the continue bit mid-word
    setup(8'h00, 8'ha3);
    arm(1'b0, 16'h6eb1, 5'h10);
    base = rx_irqs;
    pulse(1, 16'h0000);
    wait_for(0, base + 1, 60);
    check("still_active", 16'h0001, {15'h0000, TRANSFER_ACTIVE_O});
    pulse(2, 16'h00a2);
    wait_for(0, base + 2, 60);
    wait_for(2, 1, 4);
    repeat (10) @(posedge CLK_SYS_I);
    check("stop_edges", 16'h0010, {11'h000, p_rise});
    read_word(16'h006e);
    read_word(16'h00b1);
    // continuous receive until the two-word buffer overflows
    setup(8'h00, 8'ha3);
    arm(1'b0, 16'hf00f, 5'h18);
    pulse(1, 16'h0000);
    wait_for(2, 1, 200);
    check("overrun", 16'h0001, {15'h0000, OVERRUN_O});
    repeat (10) @(posedge CLK_SYS_I);
    check("overrun_edges", 16'h0018, {11'h000, p_rise});
    pulse(2, 16'h00a2);
    read_word(16'h00f0);
    check("overrun_clear", 16'h0000, {15'h0000, OVERRUN_O});
    read_word(16'h000f);
    // single receive restarted by a read with the continue bit set
    setup(8'h00, 8'ha1);
    arm(1'b0, 16'h7722, 5'h10);
    base = rx_irqs;
    pulse(1, 16'h0000);
    wait_for(0, base + 1, 60);
    wait_for(2, 1, 4);
    read_word(16'h0077);
    check("restart", 16'h0001, {15'h0000, TRANSFER_ACTIVE_O});
    wait_for(0, base + 2, 60);
    pulse(2, 16'h00a0);
    read_word(16'h0022);
    // switch off only once the active flag reads low
    wait_for(2, 1, 4);
    pulse(2, 16'h0000);
    results();
  end
endmodule : clocked_serial_transfer_engine_tb
